/* File: rtl/via_pkg.sv */
// package for the vectored interrupt arbiter: constants, register map, carriers
package via_pkg;

  // ==========================================================
  // register map (plain register port)
  localparam logic [2:0] VIA_CTRL_ADDR = 3'h0;
  localparam logic [2:0] VIA_WAKE_EN_ADDR = 3'h1;
  localparam logic [2:0] VIA_WAKE_EDGE_ADDR = 3'h2;
  localparam logic [2:0] VIA_WAKE_PEND_ADDR = 3'h3;
  localparam logic [2:0] VIA_STATUS_ADDR = 3'h4;
  localparam int VIA_CTRL_GIE_BIT = 0;
  localparam int VIA_CTRL_PORT_GROUP_INTERRUPT_ENABLE_BIT = 1;
  localparam int VIA_STATUS_SERVICE_BIT = 0;
  localparam int VIA_STATUS_BUSY_BIT = 1;
  localparam logic [7:0] VIA_WAKE_EN_RESET = 8'h00;
  localparam logic [7:0] VIA_WAKE_EDGE_RESET = 8'h00;
  localparam logic [7:0] VIA_READ_UNMAPPED = 8'h00;

  // ==========================================================
  // vectors and addresses
  localparam logic [7:0] VIA_VECTOR_BASE = 8'hE0;
  localparam logic [7:0] VIA_TRAP_OPCODE = 8'h00;
  localparam logic [7:0] VIA_ABSENT_BYTE = 8'h00;
  localparam logic [14:0] VIA_SERVICE_ENTRY = 15'h00FF;
  localparam logic [14:0] VIA_UNDERFLOW_PC = 15'h7FFF;
  localparam logic [8:0] VIA_STACK_LIMIT = 9'h06F;
  localparam int VIA_TRAP_SLOT = 15;
  localparam int VIA_PORT_SLOT = 1;
  localparam int VIA_PERIPH_FIRST_SLOT = 2;
  localparam int VIA_PERIPH_COUNT = 12;
  localparam int VIA_WAKE_COUNT = 8;

  // ==========================================================
  // cpu side carriers
  typedef struct packed {
    logic fetch_valid;
    logic fetch_exists;
    logic [7:0] fetch_byte;
    logic [14:0] fetch_addr;
    logic [14:0] pc;
    logic vis_exec;
    logic clear_trap_exec;
    logic return_from_interrupt_exec;
    logic pop_valid;
    logic [8:0] pop_addr;
    logic halted;
  } via_cpu_cmd_type;

  typedef struct packed {
    logic instr_valid;
    logic [7:0] instr_byte;
    logic pc_load;
    logic [14:0] pc_value;
    logic push;
    logic [14:0] push_addr;
    logic mem_rd;
    logic [14:0] mem_addr;
    logic wake;
    logic vis_done;
  } via_cpu_resp_type;

  typedef enum logic [1:0] {
    VIA_VIS_IDLE,
    VIA_VIS_ADDR_LO,
    VIA_VIS_CAP_HI,
    VIA_VIS_CAP_LO
  } via_vis_state_type;

endpackage

/* File: rtl/via_rank_encoder.sv */
// priority encoder turning active slots into a vector select byte
`timescale 1ns/1ns
`default_nettype none
module via_rank_encoder (
  // requests, bit n is slot n
  input wire logic [15:0] req_in,
  // selected slot and byte
  output logic [3:0] slot_out,
  output logic [7:0] vec_out
);
  import via_pkg::*;

  always_comb begin
    slot_out = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (req_in[i]) begin
        slot_out = 4'(i);
      end
    end
    vec_out = VIA_VECTOR_BASE + {3'h0, slot_out, 1'b0};
  end
endmodule
`default_nettype wire

/* File: rtl/via_wake_channel.sv */
// one port wake input: synchroniser, edge select, pending latch
`timescale 1ns/1ns
`default_nettype none
module via_wake_channel (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pin and control
  input wire logic pin_in,
  input wire logic falling_in,
  input wire logic clear_in,
  // pending
  output logic pend_out
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic pend_q;
  logic hit;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // rising when select low, falling when high
  assign hit = falling_in ? (prev_q & ~sync2_q) : (~prev_q & sync2_q);

  // an edge in the clearing cycle is kept
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pend_q <= 1'b0;
    end else if (hit) begin
      pend_q <= 1'b1;
    end else if (clear_in) begin
      pend_q <= 1'b0;
    end
  end

  assign pend_out = pend_q;
endmodule
`default_nettype wire

/* File: rtl/via_arbiter.sv */
// vectored interrupt arbiter: trap flag, port wake group, vector select
`timescale 1ns/1ns
`default_nettype none
module via_arbiter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // interrupt sources
  input wire logic [via_pkg::VIA_PERIPH_COUNT-1:0] periph_req_in,
  input wire logic [via_pkg::VIA_WAKE_COUNT-1:0] wake_pin_in,
  // cpu side
  input wire via_pkg::via_cpu_cmd_type cpu_cmd_in,
  input wire logic [7:0] mem_rdata_in,
  output via_pkg::via_cpu_resp_type cpu_resp_out
);
  import via_pkg::*;

  // ==========================================================
  // state
  logic gie_q;
  logic port_group_interrupt_enable_q;
  logic trap_pend_q;
  logic in_service_q;
  logic [7:0] wake_en_q;
  logic [7:0] wake_edge_q;
  logic [7:0] wake_pend;
  logic [7:0] wake_clear;
  logic [7:0] rdata_q;
  via_cpu_resp_type resp_q;
  via_cpu_resp_type resp_d;
  via_vis_state_type vis_q;
  logic [14:0] vis_addr_q;
  logic [7:0] vec_hi_q;
  logic [15:0] rank_req;
  logic [3:0] rank_slot;
  logic [7:0] rank_vec;
  logic [7:0] fetch_byte;
  logic fetch_trap;
  logic port_active;
  logic port_req;
  logic mask_req;
  logic mask_ack;
  logic underflow;
  logic wr_ctrl;
  logic wr_wake_en;
  logic wr_wake_edge;
  logic wr_wake_pend;

  // ==========================================================
  // register decode
  assign wr_ctrl = reg_wr_in && (reg_addr_in == VIA_CTRL_ADDR);
  assign wr_wake_en = reg_wr_in && (reg_addr_in == VIA_WAKE_EN_ADDR);
  assign wr_wake_edge = reg_wr_in && (reg_addr_in == VIA_WAKE_EDGE_ADDR);
  assign wr_wake_pend = reg_wr_in && (reg_addr_in == VIA_WAKE_PEND_ADDR);
  assign wake_clear = wr_wake_pend ? reg_wdata_in : 8'h00;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_en_q <= VIA_WAKE_EN_RESET;
    end else if (wr_wake_en) begin
      wake_en_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_edge_q <= VIA_WAKE_EDGE_RESET;
    end else if (wr_wake_edge) begin
      wake_edge_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      port_group_interrupt_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      port_group_interrupt_enable_q <= reg_wdata_in[VIA_CTRL_PORT_GROUP_INTERRUPT_ENABLE_BIT];
    end
  end

  // read data stand one cycle after the strobe; trap flag never readable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= VIA_READ_UNMAPPED;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        VIA_CTRL_ADDR: begin
          rdata_q <= 8'h00;
          rdata_q[VIA_CTRL_GIE_BIT] <= gie_q;
          rdata_q[VIA_CTRL_PORT_GROUP_INTERRUPT_ENABLE_BIT] <= port_group_interrupt_enable_q;
        end
        VIA_WAKE_EN_ADDR: begin
          rdata_q <= wake_en_q;
        end
        VIA_WAKE_EDGE_ADDR: begin
          rdata_q <= wake_edge_q;
        end
        VIA_WAKE_PEND_ADDR: begin
          rdata_q <= wake_pend;
        end
        VIA_STATUS_ADDR: begin
          rdata_q <= 8'h00;
          rdata_q[VIA_STATUS_SERVICE_BIT] <= in_service_q;
          rdata_q[VIA_STATUS_BUSY_BIT] <= (vis_q != VIA_VIS_IDLE);
        end
        default: begin
          rdata_q <= VIA_READ_UNMAPPED;
        end
      endcase
    end else begin
      rdata_q <= VIA_READ_UNMAPPED;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ==========================================================
  // port wake group
  genvar g;
  generate
    for (g = 0; g < VIA_WAKE_COUNT; g++) begin : gen_wake
      via_wake_channel u_chan (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(wake_pin_in[g]),
        .falling_in(wake_edge_q[g]),
        .clear_in(wake_clear[g]),
        .pend_out(wake_pend[g])
      );
    end
  endgenerate

  // one shared request for all eight inputs
  assign port_active = |(wake_pend & wake_en_q);
  assign port_req = port_active && port_group_interrupt_enable_q && gie_q;

  // ==========================================================
  // acknowledge logic
  assign fetch_byte = cpu_cmd_in.fetch_exists ? cpu_cmd_in.fetch_byte : VIA_ABSENT_BYTE;
  assign fetch_trap = cpu_cmd_in.fetch_valid && (fetch_byte == VIA_TRAP_OPCODE);
  assign mask_req = gie_q && !trap_pend_q && !in_service_q && ((|periph_req_in) || port_req);
  assign mask_ack = cpu_cmd_in.fetch_valid && !fetch_trap && mask_req;
  assign underflow = cpu_cmd_in.pop_valid && (cpu_cmd_in.pop_addr > VIA_STACK_LIMIT);

  // trap flag: set wins over clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      trap_pend_q <= 1'b0;
    end else if (fetch_trap) begin
      trap_pend_q <= 1'b1;
    end else if (cpu_cmd_in.clear_trap_exec) begin
      trap_pend_q <= 1'b0;
    end
  end

  // global enable: trap leaves it alone
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gie_q <= 1'b0;
    end else if (mask_ack) begin
      gie_q <= 1'b0;
    end else if (cpu_cmd_in.return_from_interrupt_exec) begin
      gie_q <= 1'b1;
    end else if (wr_ctrl) begin
      gie_q <= reg_wdata_in[VIA_CTRL_GIE_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      in_service_q <= 1'b0;
    end else if (mask_ack) begin
      in_service_q <= 1'b1;
    end else if (cpu_cmd_in.return_from_interrupt_exec) begin
      in_service_q <= 1'b0;
    end
  end

  // ==========================================================
  // arbitration ranking
  always_comb begin
    rank_req = 16'h0000;
    rank_req[VIA_TRAP_SLOT] = trap_pend_q;
    rank_req[VIA_PORT_SLOT] = port_active && port_group_interrupt_enable_q;
    rank_req[VIA_PERIPH_FIRST_SLOT +: VIA_PERIPH_COUNT] = periph_req_in;
  end

  via_rank_encoder u_rank (
    .req_in(rank_req),
    .slot_out(rank_slot),
    .vec_out(rank_vec)
  );

  // ==========================================================
  // vector select sequence
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vis_q <= VIA_VIS_IDLE;
    end else begin
      case (vis_q)
        VIA_VIS_IDLE: begin
          if (cpu_cmd_in.vis_exec) begin
            vis_q <= VIA_VIS_ADDR_LO;
          end
        end
        VIA_VIS_ADDR_LO: begin
          vis_q <= VIA_VIS_CAP_HI;
        end
        VIA_VIS_CAP_HI: begin
          vis_q <= VIA_VIS_CAP_LO;
        end
        VIA_VIS_CAP_LO: begin
          vis_q <= VIA_VIS_IDLE;
        end
        default: begin
          vis_q <= VIA_VIS_IDLE;
        end
      endcase
    end
  end

  // slot chosen in the first cycle only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vis_addr_q <= 15'h0000;
    end else if (vis_q == VIA_VIS_IDLE && cpu_cmd_in.vis_exec) begin
      vis_addr_q <= {cpu_cmd_in.pc[14:8], rank_vec};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vec_hi_q <= 8'h00;
    end else if (vis_q == VIA_VIS_CAP_HI) begin
      vec_hi_q <= mem_rdata_in;
    end
  end

  // ==========================================================
  // cpu response
  always_comb begin
    resp_d = '0;
    resp_d.instr_valid = cpu_cmd_in.fetch_valid && !mask_ack;
    resp_d.instr_byte = fetch_byte;
    resp_d.wake = cpu_cmd_in.halted && port_active;
    if (fetch_trap) begin
      resp_d.push = 1'b1;
      resp_d.push_addr = cpu_cmd_in.fetch_addr;
      resp_d.pc_load = 1'b1;
      resp_d.pc_value = VIA_SERVICE_ENTRY;
    end else if (mask_ack) begin
      resp_d.push = 1'b1;
      resp_d.push_addr = cpu_cmd_in.fetch_addr;
      resp_d.pc_load = 1'b1;
      resp_d.pc_value = VIA_SERVICE_ENTRY;
    end else if (underflow) begin
      resp_d.pc_load = 1'b1;
      resp_d.pc_value = VIA_UNDERFLOW_PC;
    end
    case (vis_q)
      VIA_VIS_IDLE: begin
        if (cpu_cmd_in.vis_exec) begin
          resp_d.mem_rd = 1'b1;
          resp_d.mem_addr = {cpu_cmd_in.pc[14:8], rank_vec};
        end
      end
      VIA_VIS_ADDR_LO: begin
        resp_d.mem_rd = 1'b1;
        resp_d.mem_addr = {vis_addr_q[14:8], vis_addr_q[7:0] + 8'h01};
      end
      VIA_VIS_CAP_HI: begin
        resp_d.mem_rd = 1'b0;
      end
      VIA_VIS_CAP_LO: begin
        resp_d.pc_load = 1'b1;
        resp_d.pc_value = {vec_hi_q[6:0], mem_rdata_in};
        resp_d.vis_done = 1'b1;
      end
      default: begin
        resp_d.mem_rd = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      resp_q <= '0;
    end else begin
      resp_q <= resp_d;
    end
  end

  assign cpu_resp_out = resp_q;
endmodule
`default_nettype wire

/* File: verification/via_checker.sv */
// port assertions for the vectored interrupt arbiter
`timescale 1ns/1ns
`default_nettype none
module via_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // cpu side
  input wire via_pkg::via_cpu_cmd_type cpu_cmd_in,
  input wire logic [7:0] mem_rdata_in,
  input wire via_pkg::via_cpu_resp_type cpu_resp_out
);
  import via_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] mem_q1;
  logic [7:0] mem_q2;
  // ==========================================================
  // last two program memory bytes
  always_ff @(posedge clk_in) begin
    mem_q1 <= mem_rdata_in;
    mem_q2 <= mem_q1;
  end
  // ==========================================================
  // properties
  property p_trap_push;
    cpu_cmd_in.fetch_valid && cpu_cmd_in.fetch_exists && cpu_cmd_in.fetch_byte == VIA_TRAP_OPCODE
    |=> cpu_resp_out.push && cpu_resp_out.instr_valid && cpu_resp_out.pc_value == VIA_SERVICE_ENTRY
    && cpu_resp_out.push_addr == $past(cpu_cmd_in.fetch_addr);
  endproperty
  a_trap_push: assert property (p_trap_push) else $error("trap fetch not taken");
  property p_absent;
    cpu_cmd_in.fetch_valid && !cpu_cmd_in.fetch_exists
    |=> cpu_resp_out.instr_byte == VIA_ABSENT_BYTE && cpu_resp_out.push;
  endproperty
  a_absent: assert property (p_absent) else $error("absent fetch not a trap");
  property p_vis_slot;
    cpu_cmd_in.vis_exec |=> cpu_resp_out.mem_rd && cpu_resp_out.mem_addr[7:5] == 3'h7
    && !cpu_resp_out.mem_addr[0] && cpu_resp_out.mem_addr[14:8] == $past(cpu_cmd_in.pc[14:8]);
  endproperty
  a_vis_slot: assert property (p_vis_slot) else $error("vector slot address wrong");
  property p_vis_pair;
    cpu_cmd_in.vis_exec ##1 cpu_resp_out.mem_rd
    |=> cpu_resp_out.mem_rd && cpu_resp_out.mem_addr == $past(cpu_resp_out.mem_addr) + 15'h0001;
  endproperty
  a_vis_pair: assert property (p_vis_pair) else $error("second vector byte address wrong");
  property p_vis_done;
    cpu_cmd_in.vis_exec |-> ##4 cpu_resp_out.vis_done && cpu_resp_out.pc_load
    && cpu_resp_out.pc_value == {mem_q2[6:0], mem_q1};
  endproperty
  a_vis_done: assert property (p_vis_done) else $error("vector not loaded");
  property p_underflow;
    cpu_cmd_in.pop_valid && cpu_cmd_in.pop_addr > VIA_STACK_LIMIT && !cpu_cmd_in.fetch_valid
    |=> cpu_resp_out.pc_load && cpu_resp_out.pc_value == VIA_UNDERFLOW_PC;
  endproperty
  a_underflow: assert property (p_underflow) else $error("stack underflow not redirected");
  property p_rd_idle;
    !reg_rd_in |=> reg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped;
    reg_rd_in && reg_addr_in > VIA_STATUS_ADDR |=> reg_rdata_out == VIA_READ_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_wake;
    cpu_resp_out.wake |-> $past(cpu_cmd_in.halted);
  endproperty
  a_wake: assert property (p_wake) else $error("wake while running");
  property p_ack_entry;
    cpu_resp_out.push && !cpu_resp_out.instr_valid |-> cpu_resp_out.pc_load
    && cpu_resp_out.pc_value == VIA_SERVICE_ENTRY;
  endproperty
  a_ack_entry: assert property (p_ack_entry) else $error("ack not to service entry");
endmodule
bind via_arbiter via_checker u_checker (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cpu_cmd_in(cpu_cmd_in),
  .mem_rdata_in(mem_rdata_in), .cpu_resp_out(cpu_resp_out));
`default_nettype wire

/* File: verification/via_cpu_model.sv */
// program memory side of the cpu answering vector reads
`timescale 1ns/1ns
`default_nettype none
module via_cpu_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // arbiter requests
  input wire via_pkg::via_cpu_resp_type cpu_resp_in,
  // program memory byte
  output logic [7:0] mem_rdata_out
);
  import via_pkg::*;
  // table byte is a fixed function of its address; idle bus toggles
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mem_rdata_out <= 8'h00;
    end else if (cpu_resp_in.mem_rd) begin
      mem_rdata_out <= cpu_resp_in.mem_addr[7:0] ^ 8'h5A;
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule
`default_nettype wire

/* File: verification/via_arbiter_tb_top.sv */
// self-checking bench for the vectored interrupt arbiter
`timescale 1ns/1ns
`default_nettype none
module via_arbiter_tb_top;
  import via_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] ra = 3'h0;
  logic [7:0] rw = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [11:0] periph = 12'h000;
  logic [7:0] pin = 8'h00;
  via_cpu_cmd_type cmd = '0;
  logic [7:0] mdata;
  via_cpu_resp_type resp;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 clk_in = ~clk_in;
  via_arbiter dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(ra), .reg_wdata_in(rw),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .periph_req_in(periph),
    .wake_pin_in(pin), .cpu_cmd_in(cmd), .mem_rdata_in(mdata), .cpu_resp_out(resp));
  via_cpu_model u_cpu (.clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_resp_in(resp), .mem_rdata_out(mdata));
  // ==========================================================
  // helpers
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_in) begin rd <= 1'b1; ra <= a; end
    @(posedge clk_in) rd <= 1'b0;
    #1 chk("reg_rdata", 16'(e), 16'(rdata));
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in) begin wr <= 1'b1; ra <= a; rw <= d; end
    @(posedge clk_in) wr <= 1'b0;
  endtask
  task automatic fetch(input logic [14:0] a, input logic [7:0] b, input logic ex, input logic p, input logic v);
    @(posedge clk_in) begin cmd.fetch_valid <= 1'b1; cmd.fetch_addr <= a; cmd.fetch_byte <= b; end
    cmd.fetch_exists <= ex;
    @(posedge clk_in) cmd.fetch_valid <= 1'b0;
    #1 chk("push", 16'(p), 16'(resp.push));
    chk("instr_valid", 16'(v), 16'(resp.instr_valid));
  endtask
  task automatic vector_select_instruction(input logic [14:0] pc, input logic [7:0] v);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = v ^ 8'h5A;
    lo = (v + 8'h01) ^ 8'h5A;
    @(posedge clk_in) begin cmd.vis_exec <= 1'b1; cmd.pc <= pc; end
    @(posedge clk_in) cmd.vis_exec <= 1'b0;
    #1 chk("vis_slot", {1'b0, pc[14:8], v}, 16'(resp.mem_addr));
    repeat (3) @(posedge clk_in);
    #1 chk("vis_target", {1'b0, hi[6:0], lo}, 16'(resp.pc_value));
  endtask
  task automatic pulse(input int k);
    @(posedge clk_in) if (k == 0) cmd.clear_trap_exec <= 1'b1; else cmd.return_from_interrupt_exec <= 1'b1;
    @(posedge clk_in) begin cmd.clear_trap_exec <= 1'b0; cmd.return_from_interrupt_exec <= 1'b0; end
  endtask
  task automatic pop(input logic [8:0] a, input logic e);
    @(posedge clk_in) begin cmd.pop_valid <= 1'b1; cmd.pop_addr <= a; end
    @(posedge clk_in) cmd.pop_valid <= 1'b0;
    #1 chk("pc_load", 16'(e), 16'(resp.pc_load));
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    for (int a = 0; a < 8; a++) rreg(3'(a), 8'h00);
    wreg(3'h6, 8'hFF);
    wreg(VIA_STATUS_ADDR, 8'hFF);
    rreg(VIA_STATUS_ADDR, 8'h00);
    rreg(3'h6, VIA_READ_UNMAPPED);
    $display("test regs done");
  endtask
  task automatic t_rank;
    vector_select_instruction(15'h0123, 8'hE0);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_in) periph <= (12'h001 << i) | ((12'h001 << i) - 12'h001);
      vector_select_instruction(15'h4A10, 8'hE4 + 8'(2 * i));
    end
    @(posedge clk_in) periph <= 12'h000;
    $display("test rank done");
  endtask
  task automatic t_trap;
    wreg(VIA_CTRL_ADDR, 8'h01);
    @(posedge clk_in) periph <= 12'h800;
    fetch(15'h0321, VIA_TRAP_OPCODE, 1'b1, 1'b1, 1'b1);
    rreg(VIA_CTRL_ADDR, 8'h01);
    fetch(15'h0400, 8'hA5, 1'b1, 1'b0, 1'b1);
    vector_select_instruction(15'h0200, 8'hFE);
    fetch(15'h7000, 8'h55, 1'b0, 1'b1, 1'b1);
    pulse(0);
    fetch(15'h0410, 8'hA5, 1'b1, 1'b1, 1'b0);
    rreg(VIA_CTRL_ADDR, 8'h00);
    rreg(VIA_STATUS_ADDR, 8'h01);
    fetch(15'h0411, VIA_TRAP_OPCODE, 1'b1, 1'b1, 1'b1);
    pulse(0);
    wreg(VIA_CTRL_ADDR, 8'h01);
    fetch(15'h0412, 8'hA5, 1'b1, 1'b0, 1'b1);
    wreg(VIA_CTRL_ADDR, 8'h00);
    vector_select_instruction(15'h0300, 8'hFA);
    pulse(1);
    rreg(VIA_CTRL_ADDR, 8'h01);
    rreg(VIA_STATUS_ADDR, 8'h00);
    @(posedge clk_in) periph <= 12'h000;
    wreg(VIA_CTRL_ADDR, 8'h00);
    $display("test trap done");
  endtask
  task automatic t_port;
    wreg(VIA_WAKE_EN_ADDR, 8'h03);
    wreg(VIA_WAKE_EDGE_ADDR, 8'h02);
    wreg(VIA_CTRL_ADDR, 8'h02);
    @(posedge clk_in) pin <= 8'h01;
    repeat (2) @(posedge clk_in);
    pin <= 8'h03;
    repeat (2) @(posedge clk_in);
    pin <= 8'h01;
    repeat (5) @(posedge clk_in);
    rreg(VIA_WAKE_PEND_ADDR, 8'h03);
    vector_select_instruction(15'h0500, 8'hE2);
    @(posedge clk_in) cmd.halted <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk("wake", 16'h0001, 16'(resp.wake));
    @(posedge clk_in) cmd.halted <= 1'b0;
    // global enable alone must not let the port group through
    wreg(VIA_CTRL_ADDR, 8'h01);
    fetch(15'h05F0, 8'hA5, 1'b1, 1'b0, 1'b1);
    wreg(VIA_CTRL_ADDR, 8'h03);
    fetch(15'h0600, 8'hA5, 1'b1, 1'b1, 1'b0);
    pulse(1);
    wreg(VIA_WAKE_PEND_ADDR, 8'h03);
    rreg(VIA_WAKE_PEND_ADDR, 8'h00);
    wreg(VIA_CTRL_ADDR, 8'h00);
    vector_select_instruction(15'h0700, 8'hE0);
    pop(9'h070, 1'b1);
    pop(9'h06F, 1'b0);
    $display("test port done");
  endtask
  // ==========================================================
  // sequence and timeout
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_rank();
    t_trap();
    t_port();
    summarize();
  end
endmodule
`default_nettype wire
